//--- core/acr_pkg.sv
package acr_pkg;

  // ==========================================================
  // Register map (index on the serial link)
  localparam logic [4:0] ACR_ADDR_SNAPSHOT = 5'h07;
  localparam logic [4:0] ACR_ADDR_CONFIG = 5'h08;
  localparam logic [4:0] ACR_ADDR_STATUS = 5'h09;
  localparam logic [4:0] ACR_ADDR_LOCK = 5'h0A;
  localparam logic [4:0] ACR_ADDR_SYNC_SNAP = 5'h0B;

  // ==========================================================
  // Field positions and values
  localparam int ACR_CNT_W = 12;
  localparam int ACR_SNAP_BIT = 1;
  localparam logic [7:0] ACR_CONFIG_RESET = 8'h00;
  localparam logic [7:0] ACR_CONFIG_WMASK = 8'hFD;
  localparam logic [11:0] ACR_COUNT_RESET = 12'h000;
  localparam logic [7:0] ACR_KEY_LOCK = 8'hCA;
  localparam logic [7:0] ACR_KEY_UNLOCK = 8'h9C;
  localparam logic [7:0] ACR_CRC_POLY = 8'h07;
  localparam logic [7:0] ACR_CRC_INIT = 8'hFF;

  // ==========================================================
  // Timing at 20 MHz
  localparam int ACR_CLK_PERIOD_NS = 50;
  localparam int ACR_RESET_TIME_NS = 20000;
  localparam int ACR_RESET_CYCLES = ACR_RESET_TIME_NS / ACR_CLK_PERIOD_NS;
  localparam int ACR_RATE_PERIOD_NS = 125000;
  localparam int ACR_RATE_CYCLES = ACR_RATE_PERIOD_NS / ACR_CLK_PERIOD_NS;
  localparam int ACR_TMR_W = 16;

  // ==========================================================
  // Types
  typedef struct packed {
    logic filter_bandwidth_select;
    logic software_reset_trigger;
    logic [1:0] output_rate_select;
    logic temp_select;
    logic converter_shutdown;
    logic reserved1;
    logic clock_output_select;
  } acr_config_t;

  typedef struct packed {
    logic [4:0] reserved;
    logic write_protect_active;
    logic crc_changed;
    logic reset_busy;
  } acr_status_t;

  typedef enum logic [2:0] {
    ACR_ST_CMD = 3'b001,
    ACR_ST_DATA = 3'b010,
    ACR_ST_IDLE = 3'b100
  } acr_spi_state_t;

endpackage

//--- core/acr_regs.sv
// Function
// - Snapshot register shows latched 12-bit counter in 11:0, upper bits zero, resets zero.
// - Config bit 0 picks shared pin: data-ready when clear, clock output when set.
// - Config bit 2 set turns off dc-dc converter and modulators.
// - Config bit 3 picks second voltage input: pins when 0, temperature sensor when 1.
// - Two-converter variant always measures temperature, ignoring the select bit.
// - Config bits 5:4 set output rate 8, 4, 2 or 1 kHz.
// - Writing one to config bit 6 starts software reset; bit self-clears after one cycle.
// - Config bit 7 picks filter bandwidth: 3.3 kHz when 0, 2 kHz when 1.
// - Status bit 0 reads one during reset, clears when configuration is possible.
// - Status bit 1 sets whenever the configuration CRC changes.
// - Status bit 2 is one once lock key 0xCA was written, zero otherwise.
// - Config bit 1 and status bits 7:3 are reserved and read zero.
// - Lock register: 0xCA protects, 0x9C unprotects; write-only, reads zero.
// - Writing the snap bit latches the counter into the snapshot; bit self-clears.
`timescale 1ns/1ps
`default_nettype none

module acr_regs
  import acr_pkg::*;
#(
  parameter bit TWO_CONVERTERS = 1'b0
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  output logic shared_clock_or_ready_pin,
  output logic converter_shutdown,
  output logic temp_sensor_measured,
  output logic [1:0] output_rate_select,
  output logic filter_bandwidth_select,
  output logic software_reset_pulse,
  output logic data_ready_output
);

  // ==========================================================
  // CRC over the configuration byte
  function automatic logic [7:0] crc8(input logic [7:0] data);
    logic [7:0] c;
    c = ACR_CRC_INIT ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ ACR_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // Reference CRC starts at the reset value's CRC so leaving reset flags nothing
  localparam logic [7:0] CRC_AT_RESET = crc8(ACR_CONFIG_RESET);

  // ==========================================================
  // Pin synchronisers
  logic [2:0] sclk_q;
  logic [1:0] cs_q;
  logic [1:0] mosi_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_q <= 3'h7;
      cs_q <= 2'h3;
      mosi_q <= 2'h0;
    end
    else
    begin
      sclk_q <= {sclk_q[1:0], spi_sclk};
      cs_q <= {cs_q[0], spi_cs_n};
      mosi_q <= {mosi_q[0], spi_mosi};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  assign sclk_rise = sclk_q[1] && !sclk_q[2];
  assign sclk_fall = !sclk_q[1] && sclk_q[2];
  assign cs_active = !cs_q[1];

  // ==========================================================
  // Serial frame: command byte {addr[4:0], read, 2'b00}, then data MSB first
  acr_spi_state_t state_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [4:0] addr_q;
  logic rd_q;
  logic [15:0] tx_q;
  logic tx_go_q;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [15:0] rd_word;

  acr_config_t cfg_q;
  acr_status_t sts_q;
  logic [11:0] snap_q;
  logic [11:0] count_q;
  logic [7:0] crc_q;
  logic [ACR_TMR_W-1:0] rst_cnt_q;

  assign wr_data = {rx_q[6:0], mosi_q[1]};
  assign wr_stb = (state_q == ACR_ST_DATA) && sclk_rise && cs_active && !rd_q
    && (bit_cnt_q == 5'd15);

  always_comb
  begin
    rd_word = 16'h0000;
    unique case (wr_data[7:3])
      ACR_ADDR_SNAPSHOT: rd_word = {4'h0, snap_q};
      ACR_ADDR_CONFIG: rd_word = {cfg_q & ACR_CONFIG_WMASK, 8'h00};
      ACR_ADDR_STATUS: rd_word = {sts_q, 8'h00};
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ACR_ST_IDLE;
      bit_cnt_q <= 5'd0;
      rx_q <= 8'h00;
      addr_q <= 5'h00;
      rd_q <= 1'b0;
    end
    else if (!cs_active)
    begin
      state_q <= ACR_ST_IDLE;
      bit_cnt_q <= 5'd0;
    end
    else
    begin
      if (state_q == ACR_ST_IDLE)
      begin
        state_q <= ACR_ST_CMD;
      end
      if (sclk_rise)
      begin
        rx_q <= wr_data;
        if (bit_cnt_q != 5'd31)
        begin
          bit_cnt_q <= bit_cnt_q + 5'd1;
        end
        if (bit_cnt_q == 5'd7)
        begin
          addr_q <= wr_data[7:3];
          rd_q <= wr_data[2];
          state_q <= ACR_ST_DATA;
        end
      end
    end
  end

  // Output word loads at the command's last edge; shifting starts one edge later
  // so the first data bit is held across the host's first sampling edge.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_q <= 16'h0000;
      tx_go_q <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end
    else
    begin
      spi_miso_oe_n <= !(cs_active && state_q == ACR_ST_DATA && rd_q);
      if (!cs_active)
      begin
        tx_go_q <= 1'b0;
      end
      else if (sclk_rise && state_q == ACR_ST_CMD && bit_cnt_q == 5'd7)
      begin
        tx_q <= rd_word;
        tx_go_q <= 1'b0;
      end
      else if (sclk_rise && state_q == ACR_ST_DATA)
      begin
        tx_go_q <= 1'b1;
      end
      else if (sclk_fall && tx_go_q)
      begin
        tx_q <= {tx_q[14:0], 1'b0};
      end
    end
  end
  assign spi_miso = tx_q[15];

  // ==========================================================
  // Configuration, lock and reset sequencing
  logic cfg_wr;
  logic lock_wr;
  logic snap_wr;
  assign cfg_wr = wr_stb && addr_q == ACR_ADDR_CONFIG && !sts_q.reset_busy
    && !sts_q.write_protect_active;
  assign lock_wr = wr_stb && addr_q == ACR_ADDR_LOCK;
  assign snap_wr = wr_stb && addr_q == ACR_ADDR_SYNC_SNAP && wr_data[ACR_SNAP_BIT];

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_q <= ACR_CONFIG_RESET;
    end
    else if (cfg_q.software_reset_trigger)
    begin
      cfg_q <= ACR_CONFIG_RESET;
    end
    else if (cfg_wr)
    begin
      cfg_q <= wr_data & ACR_CONFIG_WMASK;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sts_q <= 8'h01;
      rst_cnt_q <= '0;
    end
    else if (cfg_q.software_reset_trigger)
    begin
      sts_q <= 8'h01;
      rst_cnt_q <= '0;
    end
    else
    begin
      if (sts_q.reset_busy)
      begin
        rst_cnt_q <= rst_cnt_q + 1'b1;
        if (rst_cnt_q == ACR_TMR_W'(ACR_RESET_CYCLES - 1))
        begin
          sts_q.reset_busy <= 1'b0;
        end
      end
      if (crc8(cfg_q) != crc_q)
      begin
        sts_q.crc_changed <= 1'b1;
      end
      if (lock_wr && wr_data == ACR_KEY_LOCK)
      begin
        sts_q.write_protect_active <= 1'b1;
      end
      else if (lock_wr && wr_data == ACR_KEY_UNLOCK)
      begin
        sts_q.write_protect_active <= 1'b0;
      end
    end
  end

  // Reference CRC tracks the register so that each change flags once
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      crc_q <= CRC_AT_RESET;
    end
    else
    begin
      crc_q <= crc8(cfg_q);
    end
  end

  // ==========================================================
  // Synchronisation counter and snapshot; status and snapshot writes fall through
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_q <= ACR_COUNT_RESET;
      snap_q <= ACR_COUNT_RESET;
    end
    else
    begin
      count_q <= count_q + 12'd1;
      if (snap_wr)
      begin
        snap_q <= count_q;
      end
    end
  end

  // ==========================================================
  // Output-rate timer and shared pin
  logic [ACR_TMR_W-1:0] rate_cnt_q;
  logic [ACR_TMR_W-1:0] rate_last;
  logic half_q;
  assign rate_last = ACR_TMR_W'((ACR_RATE_CYCLES << cfg_q.output_rate_select) - 1);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rate_cnt_q <= '0;
      data_ready_output <= 1'b0;
    end
    else if (cfg_q.converter_shutdown || rate_cnt_q >= rate_last)
    begin
      rate_cnt_q <= '0;
      data_ready_output <= !cfg_q.converter_shutdown;
    end
    else
    begin
      rate_cnt_q <= rate_cnt_q + 1'b1;
      data_ready_output <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      half_q <= 1'b0;
      shared_clock_or_ready_pin <= 1'b0;
      converter_shutdown <= 1'b0;
      temp_sensor_measured <= 1'b0;
      output_rate_select <= 2'h0;
      filter_bandwidth_select <= 1'b0;
      software_reset_pulse <= 1'b0;
    end
    else
    begin
      half_q <= !half_q;
      // Clock output is ref_clk/2: the pin itself is a flop, so no faster rate exists
      shared_clock_or_ready_pin <= cfg_q.clock_output_select ? half_q
        : data_ready_output;
      converter_shutdown <= cfg_q.converter_shutdown;
      temp_sensor_measured <= TWO_CONVERTERS | cfg_q.temp_select;
      output_rate_select <= cfg_q.output_rate_select;
      filter_bandwidth_select <= cfg_q.filter_bandwidth_select;
      software_reset_pulse <= cfg_q.software_reset_trigger;
    end
  end

  // ==========================================================
  // Checks
  property p_software_reset_trigger_one_cycle;
    @(posedge ref_clk) disable iff (!arst_n)
    cfg_q.software_reset_trigger |=> !cfg_q.software_reset_trigger && sts_q.reset_busy;
  endproperty
  a_software_reset_trigger_one_cycle: assert property (p_software_reset_trigger_one_cycle) else $error("software_reset_trigger not cleared");

  property p_crc_sticky;
    @(posedge ref_clk) disable iff (!arst_n)
    sts_q.crc_changed && !cfg_q.software_reset_trigger |=> sts_q.crc_changed;
  endproperty
  a_crc_sticky: assert property (p_crc_sticky) else $error("crc flag dropped");

  property p_crc_sets;
    @(posedge ref_clk) disable iff (!arst_n)
    cfg_wr && (wr_data & ACR_CONFIG_WMASK) != cfg_q ##1 !cfg_q.software_reset_trigger
      |=> sts_q.crc_changed;
  endproperty
  a_crc_sets: assert property (p_crc_sets) else $error("crc change missed");

  property p_lock_key;
    @(posedge ref_clk) disable iff (!arst_n)
    lock_wr && wr_data == ACR_KEY_LOCK && !cfg_q.software_reset_trigger
      |=> sts_q.write_protect_active;
  endproperty
  a_lock_key: assert property (p_lock_key) else $error("lock not engaged");

  property p_locked_hold;
    @(posedge ref_clk) disable iff (!arst_n)
    sts_q.write_protect_active && !cfg_q.software_reset_trigger |=> $stable(cfg_q);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("write while locked");

  property p_snap;
    @(posedge ref_clk) disable iff (!arst_n)
    snap_wr |=> snap_q == $past(count_q);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot wrong");

  property p_reserved;
    @(posedge ref_clk) disable iff (!arst_n)
    !cfg_q.reserved1 && sts_q.reserved == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_reset_done;
    @(posedge ref_clk) disable iff (!arst_n)
    $fell(cfg_q.software_reset_trigger) |-> sts_q.reset_busy [*8] ##[1:1000] !sts_q.reset_busy;
  endproperty
  a_reset_done: assert property (p_reset_done) else $error("reset never ends");

  property p_temp;
    @(posedge ref_clk) disable iff (!arst_n)
    1'b1 |=> temp_sensor_measured == (TWO_CONVERTERS | $past(cfg_q.temp_select));
  endproperty
  a_temp: assert property (p_temp) else $error("temp select wrong");

  property p_pin;
    @(posedge ref_clk) disable iff (!arst_n)
    !cfg_q.clock_output_select |=> shared_clock_or_ready_pin == $past(data_ready_output);
  endproperty
  a_pin: assert property (p_pin) else $error("pin function wrong");

endmodule

`default_nettype wire

//--- tb/acr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========
// Host serial master, mode 3, clock idle high and still between frames
module acr_host_model (
  input wire logic ref_clk,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  // Half period of 6 cycles keeps the serial clock under 2 MHz
  localparam int HALF = 6;

  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Undriven data bits come back unknown so a floating line never matches
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, input int nbits,
                      output logic [15:0] rdat);
    logic [23:0] sh;
    sh = {cmd, wdat, 8'h00};
    rdat = '0;
    @(negedge ref_clk);
    cs_n = 1'b0;
    repeat (HALF) @(negedge ref_clk);
    for (int i = 0; i < nbits; i++)
    begin
      sclk = 1'b0;
      mosi = sh[23-i];
      repeat (HALF) @(negedge ref_clk);
      if (i >= 8)
        rdat = {rdat[14:0], miso_oe_n ? 1'bx : miso};
      sclk = 1'b1;
      repeat (HALF) @(negedge ref_clk);
    end
    cs_n = 1'b1;
    mosi = ~mosi;
    repeat (HALF) @(negedge ref_clk);
  endtask
endmodule

`default_nettype wire

//--- tb/adc_config_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module adc_config_status_regs_tb;
  import acr_pkg::*;

  logic ref_clk, arst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
  logic pin, shdn, tmp, tmp2, bw, swp, dr;
  logic [1:0] rate;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int sw_hi = 0;
  // Seed starts at 93978
  logic [31:0] seed = 32'h00016F1A;

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (swp === 1'b1)
      sw_hi <= sw_hi + 1;
  end

  acr_host_model host_u (.ref_clk(ref_clk), .sclk(spi_sclk), .cs_n(spi_cs_n),
    .mosi(spi_mosi), .miso(spi_miso), .miso_oe_n(spi_miso_oe_n));

  acr_regs dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n), .shared_clock_or_ready_pin(pin),
    .converter_shutdown(shdn), .temp_sensor_measured(tmp), .output_rate_select(rate),
    .filter_bandwidth_select(bw), .software_reset_pulse(swp), .data_ready_output(dr));

  // Two-converter variant listens to the same frames; only its channel routing is watched
  acr_regs #(.TWO_CONVERTERS(1'b1)) dut2_u (.ref_clk(ref_clk), .arst_n(arst_n),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(),
    .spi_miso_oe_n(), .shared_clock_or_ready_pin(), .converter_shutdown(),
    .temp_sensor_measured(tmp2), .output_rate_select(), .filter_bandwidth_select(),
    .software_reset_pulse(), .data_ready_output());

  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] st_exp(input logic p, input logic c, input logic b);
    return {5'h00, p, c, b, 8'h00};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [15:0] x;
    host_u.xfer({a, 3'b000}, d, 16, x);
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    host_u.xfer({a, 3'b100}, 8'h00, 24, d);
  endtask

  task automatic pin_chk(input logic clk_mode);
    logic p, d;
    repeat (4)
    begin
      p = pin;
      d = dr;
      @(negedge ref_clk);
      chk("pin", {15'h0000, clk_mode ? ~p : d}, {15'h0000, pin});
    end
  endtask

  task automatic period(input int r);
    int n;
    n = 0;
    while (dr !== 1'b1 && n < 30000)
    begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    n = 1;
    while (dr !== 1'b1 && n < 30000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("period", 16'(2500 << r), 16'(n));
  endtask

  // ==========
  // Sequence
  initial
  begin
    logic [15:0] r, s1;
    logic [7:0] v, e, cur;
    logic crc_f;
    int c1;
    arst_n = 1'b0;
    cur = 8'h00;
    crc_f = 1'b0;
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
    chk("idle", 16'h0001, {7'h00, shdn, tmp, rate, bw, swp, dr, pin, spi_miso_oe_n});
    // Refused while the reset is still in progress
    wr(ACR_ADDR_CONFIG, 8'h81);
    rd(ACR_ADDR_STATUS, r);
    chk("status", st_exp(1'b0, 1'b0, 1'b1), r);
    rd(ACR_ADDR_CONFIG, r);
    chk("config", 16'h0000, r);
    rd(ACR_ADDR_SNAPSHOT, r);
    chk("snap", 16'h0000, r);
    repeat (400) @(negedge ref_clk);
    rd(ACR_ADDR_STATUS, r);
    chk("status", st_exp(1'b0, 1'b0, 1'b0), r);
    for (int i = 0; i < 10; i++)
    begin
      v = (i == 0) ? 8'h02 : (8'(rnd()) & 8'hBF);
      wr(ACR_ADDR_CONFIG, v);
      e = v & 8'hBD;
      crc_f = crc_f | (e != cur);
      cur = e;
      rd(ACR_ADDR_CONFIG, r);
      chk("config", {e, 8'h00}, r);
      chk("outs", {11'h000, e[7], e[5:4], e[3], e[2]}, {11'h000, bw, rate, tmp, shdn});
      chk("temp2", 16'h0001, {15'h0000, tmp2});
      rd(ACR_ADDR_STATUS, r);
      chk("status", st_exp(1'b0, crc_f, 1'b0), r);
      pin_chk(e[0]);
    end
    wr(ACR_ADDR_SNAPSHOT, 8'hFF);
    wr(ACR_ADDR_STATUS, 8'hFF);
    rd(ACR_ADDR_STATUS, r);
    chk("status", st_exp(1'b0, crc_f, 1'b0), r);
    rd(ACR_ADDR_SNAPSHOT, r);
    chk("snap", 16'h0000, r);
    // Protection key, blocked write, read-back, release key
    wr(ACR_ADDR_LOCK, ACR_KEY_LOCK);
    rd(ACR_ADDR_STATUS, r);
    chk("status", st_exp(1'b1, crc_f, 1'b0), r);
    wr(ACR_ADDR_CONFIG, ~cur & 8'hBD);
    rd(ACR_ADDR_CONFIG, r);
    chk("config", {cur, 8'h00}, r);
    rd(ACR_ADDR_LOCK, r);
    chk("lock", 16'h0000, r);
    wr(ACR_ADDR_LOCK, ACR_KEY_UNLOCK);
    rd(ACR_ADDR_STATUS, r);
    chk("status", st_exp(1'b0, crc_f, 1'b0), r);
    rd(5'h1F, r);
    chk("unmapped", 16'h0000, r);
    // Counter capture: bit 0 alone does nothing, bit 1 latches
    wr(ACR_ADDR_SYNC_SNAP, 8'h01);
    rd(ACR_ADDR_SNAPSHOT, r);
    chk("snap", 16'h0000, r);
    wr(ACR_ADDR_SYNC_SNAP, 8'h02);
    c1 = cyc;
    rd(ACR_ADDR_SNAPSHOT, s1);
    chk("snaphi", 16'h0000, {12'h000, s1[15:12]});
    wr(ACR_ADDR_SYNC_SNAP, 8'h02);
    c1 = cyc - c1;
    rd(ACR_ADDR_SNAPSHOT, r);
    chk("snapdiff", {4'h0, 12'(c1)}, {4'h0, 12'(r - s1)});
    for (int k = 0; k < 4; k = k + 3)
    begin
      cur = {2'b00, 2'(k), 4'h0};
      wr(ACR_ADDR_CONFIG, cur);
      period(k);
      pin_chk(1'b0);
    end
    // Software reset from a non-zero setting
    sw_hi = 0;
    wr(ACR_ADDR_CONFIG, 8'h40 | cur);
    chk("swpulse", 16'h0001, 16'(sw_hi));
    // Status first: the 400-cycle busy window is shorter than two read frames
    rd(ACR_ADDR_STATUS, r);
    chk("status", st_exp(1'b0, 1'b1, 1'b1), r);
    rd(ACR_ADDR_CONFIG, r);
    chk("config", 16'h0000, r);
    test_done();
  end

  initial
  begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    test_done();
  end
endmodule

`default_nettype wire
